// ### bit_sync.sv
// multi-bit two-flop level synchroniser, bits crossed independently
// assumes each bit is a slow level, no word coherence needed
`timescale 1ns/1ps
module bit_sync
  import flash_scan_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("bit_sync width must be at least one");
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// ### flash_control_status_scan.sv
// flash control and status scan register, tap side on tck, flash side on clk_i
// assumes tap controller decodes states; flash core events arrive on clk_i
// Behaviour
// - capture loads flash status into the shift stages, update applies shifted control
// - control bits change only on update, otherwise they hold their value
// - contents reset only by power-up reset or test-port reset
// - bit 0 sticky on erase failure, cleared by writing 1 while not busy
// - bit 1 sticky on program failure, cleared by writing 1 while not busy
// - bit 2 busy when clocks not ready or flash working, resets to 1
// - bit 3 shows the two-entry write buffer is full
// - bit 4 sticky when a write arrives while the buffer is full
// - writing 1 clears bit 4, ignored while busy
// - bit 5 low under protection, blocking read, program, erase but not special erase
// - bit 6 blank flash holds the core in reset
// - bit 7 enables programming by serial write requests, default off
// - bit 8 enables serial page erase, default off
// - bit 10 enables serial special erase, default off
// - bit 14 set skips automatic verify after program or erase
// - port disabled: ignore other writes, clear errors, invalid capture, ignore requests
`timescale 1ns/1ps
module flash_control_status_scan
  import flash_scan_pkg::*;
#(
  parameter int WORD_W = SCAN_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tck_i,
  input wire logic tap_reset_i,
  input wire tap_view_t tap_i,
  input wire flash_cond_t cond_i,
  input wire serial_req_t req_i,
  output logic tdo_o,
  output logic program_enable_o,
  output logic page_erase_enable_o,
  output logic special_erase_enable_o,
  output logic verify_disable_o,
  output logic serial_flash_port_enable_o,
  output logic core_hold_reset_o,
  output logic read_go_o,
  output logic program_go_o,
  output logic page_erase_go_o,
  output logic special_erase_go_o
);

  generate
    if (WORD_W != SCAN_W) begin : g_chk
      $error("scan word width must be 16");
    end
  endgenerate

  // ---------------- tck domain ----------------
  logic [SCAN_W-1:0] shift_reg;
  logic [SCAN_W-1:0] update_word;
  logic update_toggle;
  logic [SCAN_W-1:0] status_tck;

  // status word crossed into tck domain
  logic [SCAN_W-1:0] status_word;

  bit_sync #(
    .WIDTH(SCAN_W)
  ) u_status_sync (
    .clk_i(tck_i),
    .rst_i(tap_reset_i),
    .d_i(status_word),
    .q_o(status_tck)
  );

  // shift stages: capture, shift towards tdo, hold otherwise
  always_ff @(posedge tck_i) begin
    if (tap_reset_i) begin
      shift_reg <= RST_SCAN;
    end else if (tap_i.selected && tap_i.capture_dr) begin
      if (status_tck[POS_PORT_EN]) begin
        shift_reg <= status_tck;
      end else begin
        shift_reg <= INVALID_CAPTURE;
      end
    end else if (tap_i.selected && tap_i.shift_dr) begin
      shift_reg <= {tap_i.tdi, shift_reg[SCAN_W-1:1]};
    end
  end

  assign tdo_o = shift_reg[0];

  // update: latch word and flag it to clk domain
  always_ff @(posedge tck_i) begin
    if (tap_reset_i) begin
      update_word <= RST_SCAN;
      update_toggle <= 1'b0;
    end else if (tap_i.selected && tap_i.update_dr) begin
      update_word <= shift_reg;
      update_toggle <= ~update_toggle;
    end
  end

  // ---------------- clk_i domain ----------------
  logic toggle_sync;
  logic tap_reset_sync;
  logic toggle_seen;
  logic update_pulse;
  logic content_reset;

  bit_sync #(
    .WIDTH(2)
  ) u_ctrl_sync (
    .clk_i(clk_i),
    .rst_i(1'b0),
    .d_i({update_toggle, tap_reset_i}),
    .q_o({toggle_sync, tap_reset_sync})
  );

  // only power-up and test-port reset touch the contents
  assign content_reset = sys_rst_i | tap_reset_sync;

  always_ff @(posedge clk_i) begin
    toggle_seen <= toggle_sync;
  end

  // one pulse per update-dr, suppressed during reset
  assign update_pulse = (toggle_sync != toggle_seen) && !content_reset;

  // control bits
  logic port_en;
  logic prog_en;
  logic page_en;
  logic special_en;
  logic verify_dis;

  always_ff @(posedge clk_i) begin
    if (content_reset) begin
      port_en <= RST_CTRL;
      prog_en <= RST_CTRL;
      page_en <= RST_CTRL;
      special_en <= RST_CTRL;
      verify_dis <= RST_CTRL;
    end else if (update_pulse) begin
      port_en <= update_word[POS_PORT_EN];
      if (port_en) begin
        prog_en <= update_word[POS_PROG_EN];
        page_en <= update_word[POS_PAGE_EN];
        special_en <= update_word[POS_SPECIAL_EN];
        verify_dis <= update_word[POS_VERIFY_DIS];
      end
    end
  end

  // read-only status
  logic busy;
  logic buf_full;
  logic access_ok;
  logic blank;

  always_ff @(posedge clk_i) begin
    if (content_reset) begin
      busy <= RST_BUSY;
      buf_full <= RST_FLAG;
      access_ok <= RST_FLAG;
      blank <= RST_FLAG;
    end else begin
      busy <= !cond_i.clocks_ready || cond_i.flash_active;
      buf_full <= cond_i.buffer_full;
      access_ok <= !cond_i.protect_active;
      blank <= cond_i.blank_flash;
    end
  end

  // sticky error flags, set wins over write-1 clear, port disable clears all
  logic erase_err;
  logic prog_err;
  logic overrun;
  logic clear_ok;
  logic next_erase_err;
  logic next_prog_err;
  logic next_overrun;

  assign clear_ok = update_pulse && port_en && !busy;

  always_comb begin
    next_erase_err = erase_err;
    next_prog_err = prog_err;
    next_overrun = overrun;
    if (clear_ok && update_word[POS_ERASE_ERR]) begin
      next_erase_err = 1'b0;
    end
    if (clear_ok && update_word[POS_PROG_ERR]) begin
      next_prog_err = 1'b0;
    end
    if (clear_ok && update_word[POS_OVERRUN]) begin
      next_overrun = 1'b0;
    end
    if (cond_i.erase_fail) begin
      next_erase_err = 1'b1;
    end
    if (cond_i.program_fail) begin
      next_prog_err = 1'b1;
    end
    if (cond_i.buffer_write && cond_i.buffer_full) begin
      next_overrun = 1'b1;
    end
    if (!port_en) begin
      next_erase_err = 1'b0;
      next_prog_err = 1'b0;
      next_overrun = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (content_reset) begin
      erase_err <= RST_FLAG;
      prog_err <= RST_FLAG;
      overrun <= RST_FLAG;
    end else begin
      erase_err <= next_erase_err;
      prog_err <= next_prog_err;
      overrun <= next_overrun;
    end
  end

  // status word for capture; reserved bits and bit 9 read zero
  logic [SCAN_W-1:0] next_status_word;

  always_comb begin
    next_status_word = RST_SCAN;
    next_status_word[POS_ERASE_ERR] = erase_err;
    next_status_word[POS_PROG_ERR] = prog_err;
    next_status_word[POS_BUSY] = busy;
    next_status_word[POS_BUF_FULL] = buf_full;
    next_status_word[POS_OVERRUN] = overrun;
    next_status_word[POS_ACCESS] = access_ok;
    next_status_word[POS_BLANK] = blank;
    next_status_word[POS_PROG_EN] = prog_en;
    next_status_word[POS_PAGE_EN] = page_en;
    next_status_word[POS_SPECIAL_EN] = special_en;
    next_status_word[POS_VERIFY_DIS] = verify_dis;
    next_status_word[POS_PORT_EN] = port_en;
  end

  always_ff @(posedge clk_i) begin
    if (content_reset) begin
      status_word <= {RST_CTRL, RST_CTRL, 10'h000, RST_FLAG, RST_BUSY, 2'b00};
    end else begin
      status_word <= next_status_word;
    end
  end

  // control outputs
  always_ff @(posedge clk_i) begin
    if (content_reset) begin
      program_enable_o <= RST_CTRL;
      page_erase_enable_o <= RST_CTRL;
      special_erase_enable_o <= RST_CTRL;
      verify_disable_o <= RST_CTRL;
      serial_flash_port_enable_o <= RST_CTRL;
      core_hold_reset_o <= RST_FLAG;
    end else begin
      program_enable_o <= prog_en;
      page_erase_enable_o <= page_en;
      special_erase_enable_o <= special_en;
      verify_disable_o <= verify_dis;
      serial_flash_port_enable_o <= port_en;
      core_hold_reset_o <= blank;
    end
  end

  // serial request gating
  always_ff @(posedge clk_i) begin
    if (content_reset) begin
      read_go_o <= 1'b0;
      program_go_o <= 1'b0;
      page_erase_go_o <= 1'b0;
      special_erase_go_o <= 1'b0;
    end else begin
      read_go_o <= req_i.read_req && port_en && access_ok;
      program_go_o <= req_i.program_req && port_en && access_ok && prog_en;
      page_erase_go_o <= req_i.page_erase_req && port_en && access_ok && page_en;
      special_erase_go_o <= req_i.special_erase_req && port_en && special_en;
    end
  end

endmodule

// ### flash_scan_checker.sv
// assertions on the scan register ports, clk_i domain
// assumes go outputs follow requests by one clk
`timescale 1ns/1ps
module flash_scan_checker
  import flash_scan_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic tap_reset_i,
  input wire tap_view_t tap_i,
  input wire flash_cond_t cond_i,
  input wire serial_req_t req_i,
  input wire logic program_enable_o,
  input wire logic page_erase_enable_o,
  input wire logic special_erase_enable_o,
  input wire logic verify_disable_o,
  input wire logic serial_flash_port_enable_o,
  input wire logic core_hold_reset_o,
  input wire logic read_go_o,
  input wire logic program_go_o,
  input wire logic page_erase_go_o,
  input wire logic special_erase_go_o
);
  logic [7:0] age;
  logic [4:0] ctl;
  logic pen;
  assign pen = serial_flash_port_enable_o;
  assign ctl = {program_enable_o, page_erase_enable_o, special_erase_enable_o, verify_disable_o, pen};
  always_ff @(posedge clk_i) begin
    if (tap_i.update_dr || tap_reset_i || sys_rst_i) begin
      age <= 8'h00;
    end else if (age != 8'hff) begin
      age <= age + 8'h01;
    end
  end
  sequence s_spe;
    req_i.special_erase_req ##1 (special_erase_enable_o && pen);
  endsequence
  a_read_go_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    read_go_o |-> $past(req_i.read_req) && pen) else $error("read go without request");
  a_prog_go_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    program_go_o |-> $past(req_i.program_req) && program_enable_o && pen) else $error("program go not gated");
  a_page_go_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    page_erase_go_o |-> $past(req_i.page_erase_req) && page_erase_enable_o && pen) else $error("page go not gated");
  a_special_go: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_spe |-> special_erase_go_o) else $error("special erase request lost");
  a_blank_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cond_i.blank_flash [*3] |=> core_hold_reset_o) else $error("core not held on blank flash");
  a_blank_free: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !cond_i.blank_flash [*3] |=> !core_hold_reset_o) else $error("core held without blank flash");
  a_reset_quiet: assert property (@(posedge clk_i)
    sys_rst_i ##1 sys_rst_i |-> ctl == 5'h00 && !core_hold_reset_o) else $error("outputs active in reset");
  a_ctl_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(ctl) |-> age < 8'h10) else $error("controls changed without update");
endmodule
bind flash_control_status_scan flash_scan_checker chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .tap_reset_i(tap_reset_i), .tap_i(tap_i), .cond_i(cond_i), .req_i(req_i), .program_enable_o(program_enable_o),
  .page_erase_enable_o(page_erase_enable_o), .special_erase_enable_o(special_erase_enable_o),
  .verify_disable_o(verify_disable_o), .serial_flash_port_enable_o(serial_flash_port_enable_o),
  .core_hold_reset_o(core_hold_reset_o), .read_go_o(read_go_o), .program_go_o(program_go_o),
  .page_erase_go_o(page_erase_go_o), .special_erase_go_o(special_erase_go_o));

// ### flash_scan_pkg.sv
// constants and carriers for the flash control and status scan register
// assumes a 16-bit scan cell driven by an external tap controller
package flash_scan_pkg;

  localparam int SCAN_W = 16;

  // bit positions inside the scan word
  localparam int POS_ERASE_ERR = 0;
  localparam int POS_PROG_ERR = 1;
  localparam int POS_BUSY = 2;
  localparam int POS_BUF_FULL = 3;
  localparam int POS_OVERRUN = 4;
  localparam int POS_ACCESS = 5;
  localparam int POS_BLANK = 6;
  localparam int POS_PROG_EN = 7;
  localparam int POS_PAGE_EN = 8;
  localparam int POS_SPECIAL_EN = 10;
  localparam int POS_VERIFY_DIS = 14;
  localparam int POS_PORT_EN = 15;

  // reset values
  localparam logic RST_BUSY = 1'b1;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_CTRL = 1'b0;
  localparam logic [SCAN_W-1:0] RST_SCAN = 16'h0000;
  localparam logic [SCAN_W-1:0] INVALID_CAPTURE = 16'h0000;

  // synchroniser depth
  localparam int SYNC_STAGES = 2;

  // flash core condition and events, clk_i domain
  typedef struct packed {
    logic clocks_ready;
    logic flash_active;
    logic erase_fail;
    logic program_fail;
    logic buffer_full;
    logic buffer_write;
    logic protect_active;
    logic blank_flash;
  } flash_cond_t;

  // serial flash requests, clk_i domain, one-cycle pulses
  typedef struct packed {
    logic read_req;
    logic program_req;
    logic page_erase_req;
    logic special_erase_req;
  } serial_req_t;

  // tap controller view for this data register, tck domain
  typedef struct packed {
    logic selected;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic tdi;
  } tap_view_t;

endpackage

// ### jtag_host_model.sv
// serial test-port host driving the tap view and the test clock
// assumes tck rests low between frames, 32 ns period inside them
`timescale 1ns/1ps
module jtag_host_model
  import flash_scan_pkg::*;
(
  input wire logic tdo_i,
  output logic tck_o,
  output tap_view_t tap_o
);
  initial begin
    tck_o = 1'b0;
    tap_o = '0;
  end
  task automatic pulse();
    #16 tck_o = 1'b1;
    #16 tck_o = 1'b0;
  endtask
  // idle clocks, capture, 16 shifts lsb first, optional update
  task automatic scan(input logic [15:0] w, input logic upd, output logic [15:0] r);
    repeat (3) pulse();
    tap_o = '{1'b1, 1'b1, 1'b0, 1'b0, ~tap_o.tdi};
    pulse();
    tap_o.capture_dr = 1'b0;
    tap_o.shift_dr = 1'b1;
    for (int k = 0; k < 16; k++) begin
      tap_o.tdi = w[k];
      r[k] = tdo_i;
      pulse();
    end
    tap_o.shift_dr = 1'b0;
    tap_o.tdi = ~w[15];
    tap_o.update_dr = upd;
    pulse();
    tap_o.update_dr = 1'b0;
    tap_o.selected = 1'b0;
  endtask
endmodule

// ### tb_top.sv
// self-checking bench for the flash control and status scan register
// assumes the host model provides the test clock inside frames
`timescale 1ns/1ps
module tb_top;
  import flash_scan_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tap_reset_i = 1'b1;
  logic tck, tdo, hold;
  tap_view_t tap;
  flash_cond_t cond;
  serial_req_t req;
  logic [4:0] ctl;
  logic [3:0] go;
  logic [15:0] cap_r, w, prev;
  logic [15:0] cap_q[$], go_q[$], ctl_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 32'hd7f0_8305;
  event cap_ev, ctl_ev;
  always #12.5 clk_i = ~clk_i;
  jtag_host_model host_u (.tdo_i(tdo), .tck_o(tck), .tap_o(tap));
  flash_control_status_scan dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tap_reset_i(tap_reset_i),
    .tap_i(tap), .cond_i(cond), .req_i(req), .tdo_o(tdo), .program_enable_o(ctl[4]), .page_erase_enable_o(ctl[3]),
    .special_erase_enable_o(ctl[2]), .verify_disable_o(ctl[1]), .serial_flash_port_enable_o(ctl[0]),
    .core_hold_reset_o(hold), .read_go_o(go[3]), .program_go_o(go[2]), .page_erase_go_o(go[1]),
    .special_erase_go_o(go[0]));
  task automatic fail(input string m);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic cmp_cap(input logic [15:0] a, input logic [15:0] e);
    check_count++;
    if (a !== e) fail($sformatf("capture %h, expected %h", a, e));
  endtask
  task automatic cmp_ctl(input logic [15:0] a, input logic [15:0] e);
    check_count++;
    if (a !== e) fail($sformatf("controls %h, expected %h", a, e));
  endtask
  task automatic cmp_go(input logic [15:0] a, input logic [15:0] e);
    check_count++;
    if (a !== e) fail($sformatf("go %h, expected %h", a, e));
  endtask
  always @(cap_ev) cmp_cap(cap_r, cap_q.pop_front());
  always @(ctl_ev) cmp_ctl({10'h000, hold, ctl}, ctl_q.pop_front());
  always @(negedge clk_i) begin
    if (go !== 4'h0) begin
      if (go_q.size() == 0) fail("unexpected go pulse");
      else cmp_go({12'h000, go}, go_q.pop_front());
    end
  end
  task automatic scan(input logic [15:0] wr, input logic [15:0] e, input logic upd = 1'b1);
    cap_q.push_back(e);
    repeat (3) @(posedge clk_i);
    host_u.scan(wr, upd, cap_r);
    ->cap_ev;
    repeat (12) @(posedge clk_i);
  endtask
  task automatic chk(input logic [5:0] e);
    ctl_q.push_back({10'h000, e});
    @(posedge clk_i);
    #1 ->ctl_ev;
  endtask
  task automatic setc(input logic [7:0] c);
    @(posedge clk_i);
    #1 cond = flash_cond_t'(c);
  endtask
  task automatic ev(input logic [7:0] m);
    setc(cond | m);
    setc(cond & ~m);
  endtask
  task automatic rq(input logic [3:0] r, input logic [3:0] e);
    if (e != 4'h0) go_q.push_back({12'h000, e});
    @(posedge clk_i);
    #1 req = serial_req_t'(r);
    @(posedge clk_i);
    #1 req = '0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tap_rst();
    tap_reset_i = 1'b1;
    repeat (3) host_u.pulse();
    @(posedge clk_i);
    #1 tap_reset_i = 1'b0;
    sys_rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail("run timed out");
    results();
  end
  initial begin
    cond = flash_cond_t'(8'h80);
    req = '0;
    repeat (8) @(posedge clk_i);
    tap_rst();
    scan(16'h7fff, 16'h0000);
    chk(6'h00);
    $display("test 1 done");
    scan(16'h8000, 16'h0000);
    scan(16'hffff, 16'h8020);
    chk(6'h1f);
    scan(16'h0000, 16'hc5a0, 1'b0);
    scan(16'h0000, 16'hc5a0, 1'b0);
    $display("test 2 done");
    ev(8'h20);
    ev(8'h10);
    setc(8'h88);
    ev(8'h04);
    scan(16'h0000, 16'hc5bb, 1'b0);
    setc(8'hc0);
    scan(16'hffff, 16'hc5b7);
    scan(16'h0000, 16'hc5b7, 1'b0);
    setc(8'h80);
    scan(16'hc580, 16'hc5b3);
    scan(16'hffff, 16'hc5b3);
    scan(16'h0000, 16'hc5a0, 1'b0);
    $display("test 3 done");
    setc(8'h83);
    scan(16'h0000, 16'hc5c0, 1'b0);
    chk(6'h3f);
    rq(4'hf, 4'h1);
    setc(8'h80);
    rq(4'hf, 4'hf);
    chk(6'h1f);
    $display("test 4 done");
    prev = 16'hc5a0;
    repeat (4) begin
      w = 16'($random(seed)) | 16'h8000;
      scan(w, prev);
      prev = (w & 16'h4580) | 16'h8020;
    end
    scan(16'h0000, prev, 1'b0);
    chk({1'b0, w[7], w[8], w[10], w[14], 1'b1});
    $display("test 5 done");
    scan(16'h0000, prev);
    chk(6'h00);
    rq(4'hf, 4'h0);
    ev(8'h20);
    scan(16'h8000, 16'h0000);
    scan(16'h0000, 16'h8020, 1'b0);
    $display("test 6 done");
    scan(16'hffff, 16'h8020);
    tap_rst();
    scan(16'h0000, 16'h0000, 1'b0);
    chk(6'h00);
    $display("test 7 done");
    if (go_q.size() != 0) fail("go pulse missing");
    results();
  end
endmodule
